// file: verilog/mpc_pkg.sv
// Purpose: Shared constants for the multiphase configuration register bank and its host.
// Assumes: One clock, active-low asynchronous reset.
// Notes:   Command codes are link addresses; host offsets are AHB-Lite byte addresses.
`default_nettype none
package mpc_pkg;
  // ---------------------------------------------------------------
  // Link command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CFG_TEN = 8'hba;
  localparam logic [7:0] CMD_CFG_ELEVEN = 8'hbb;
  localparam logic [7:0] CMD_CFG_TWELVE = 8'hbc;
  localparam logic [7:0] CMD_LIMIT = 8'hd0;
  localparam logic [7:0] CMD_IMB = 8'hd3;
  localparam logic [7:0] CMD_MIRROR = 8'hdb;

  // ---------------------------------------------------------------
  // Transaction kinds
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {KIND_BYTE, KIND_WORD, KIND_BLOCK} mpc_kind_t;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_W = 48;
  localparam int LIM_W = 14;
  localparam int TWO_PH_BIT = 9;
  localparam int THREE_PH_BIT = 8;
  localparam int MIRROR_BIT = 0;
  localparam int TEMP_OFF_BIT = 13;
  localparam int ISOL_BIT = 12;
  localparam int OV_OFF_BIT = 11;
  localparam int DOWN_LSB = 8;
  localparam int UP_LSB = 6;
  localparam int SHARE_LSB = 4;
  localparam int OCL_LSB = 0;
  localparam logic [6:0] OCL_BASE_AMPS = 7'd14;
  localparam logic [6:0] OCL_STEP_AMPS = 7'd4;

  // ---------------------------------------------------------------
  // Host register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_WLO = 8'h04;
  localparam logic [7:0] H_WHI = 8'h08;
  localparam logic [7:0] H_RLO = 8'h0c;
  localparam logic [7:0] H_RHI = 8'h10;
  localparam logic [7:0] H_STAT = 8'h14;
  localparam int CTRL_KIND_LSB = 8;
  localparam int CTRL_WR_BIT = 10;
  localparam int CTRL_GO_BIT = 31;
endpackage
`default_nettype wire

// file: verilog/mpc_link_if.sv
// Purpose: Transaction link between the host end and the register bank.
// Assumes: Request fields stand from req rising until ack is seen.
// Notes:   Abstracts the serial management bus to whole transactions.
`timescale 1ns/100ps
`default_nettype none
interface mpc_link_if;
  logic req;
  logic [1:0] kind;
  logic wr;
  logic [7:0] cmd;
  logic [47:0] wdata;
  logic ack;
  logic err;
  logic [47:0] rdata;

  modport dev (input req, kind, wr, cmd, wdata, output ack, err, rdata);
  modport host (output req, kind, wr, cmd, wdata, input ack, err, rdata);
endinterface
`default_nettype wire

// file: verilog/mpc_dev_end.sv
// Purpose: Configuration and status register bank of a two-channel multiphase controller.
// Assumes: Host keeps request fields stable until ack; defaults arrive on nvm_load.
// Notes:   One transaction answered per request, one cycle after it is taken.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mpc_dev_end (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link to host
  mpc_link_if.dev link,
  // Nonvolatile defaults
  input wire logic nvm_load,
  input wire logic [47:0] nvm_cfg_ten,
  input wire logic [47:0] nvm_cfg_eleven,
  input wire logic [47:0] nvm_cfg_twelve,
  input wire logic [13:0] nvm_limit_p0,
  input wire logic [13:0] nvm_limit_p1,
  // Power stage status
  input wire logic [5:0] imb_event_a,
  input wire logic [2:0] imb_event_b,
  input wire logic [2:0] active_phases_a,
  input wire logic [2:0] active_phases_b,
  // Settings to power stage
  output logic [1:0] chan_b_phase_count,
  output logic chan_b_temp_sense_disable,
  output logic fault_isolation_sel,
  output logic chan_b_fixed_overvoltage_off,
  output logic [2:0] dac_offset_falling_a,
  output logic [2:0] dac_offset_falling_b,
  output logic [2:0] dac_offset_rising_a,
  output logic [2:0] dac_offset_rising_b,
  output logic [1:0] imbalance_warn_threshold_a,
  output logic [1:0] imbalance_warn_threshold_b,
  output logic [6:0] per_phase_current_limit_a,
  output logic [6:0] per_phase_current_limit_b
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Two-bit code to DAC counter offset 0, 2, 4, 6
  function automatic logic [2:0] dac_ofs(input logic [1:0] code);
    dac_ofs = {code, 1'b0};
  endfunction

  // Limit code to amps
  function automatic logic [6:0] ocl_amps(input logic [3:0] code);
    ocl_amps = 7'(mpc_pkg::OCL_BASE_AMPS + mpc_pkg::OCL_STEP_AMPS * {3'b000, code});
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [47:0] cfg_q [3];
  logic [13:0] limit_q [2];
  logic page_q;
  logic [5:0] flags_a_q;
  logic [2:0] flags_b_q;
  logic ack_q;
  logic err_q;
  logic [47:0] rdata_q;

  logic take;
  logic bad;
  logic [47:0] rd_d;
  logic [2:0] wr_cfg;
  logic wr_lim;
  logic wr_page;
  logic wr_mir;
  logic rd_imb;
  logic [1:0] cfg_idx;
  logic [47:0] cfg_new;

  assign take = link.req && !ack_q;
  assign cfg_idx = 2'(link.cmd - mpc_pkg::CMD_CFG_TEN);

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // Kind check, read mux and write strobes
  always_comb begin
    bad = 1'b0;
    rd_d = '0;
    wr_cfg = 3'b000;
    wr_lim = 1'b0;
    wr_page = 1'b0;
    wr_mir = 1'b0;
    rd_imb = 1'b0;
    case (link.cmd)
      mpc_pkg::CMD_PAGE: begin
        if (link.kind != mpc_pkg::KIND_BYTE) begin
          bad = 1'b1;
        end else if (link.wr) begin
          bad = (link.wdata[7:1] != 7'h00);
          wr_page = !bad;
        end else begin
          rd_d = {47'h0, page_q};
        end
      end
      mpc_pkg::CMD_CFG_TEN, mpc_pkg::CMD_CFG_ELEVEN, mpc_pkg::CMD_CFG_TWELVE: begin
        if (link.kind != mpc_pkg::KIND_BLOCK) begin
          bad = 1'b1;
        end else if (link.wr) begin
          wr_cfg[cfg_idx] = 1'b1;
        end else begin
          rd_d = cfg_q[cfg_idx];
        end
      end
      mpc_pkg::CMD_LIMIT: begin
        if (link.kind != mpc_pkg::KIND_WORD) begin
          bad = 1'b1;
        end else if (link.wr) begin
          wr_lim = 1'b1;
        end else begin
          rd_d = {34'h0, limit_q[page_q]};
        end
      end
      mpc_pkg::CMD_IMB: begin
        if (link.kind != mpc_pkg::KIND_WORD || link.wr) begin
          bad = 1'b1;
        end else begin
          rd_imb = 1'b1;
          if (!page_q) begin
            rd_d = {39'h0, flags_a_q, active_phases_a};
          end else begin
            rd_d = {42'h0, flags_b_q, active_phases_b};
          end
        end
      end
      mpc_pkg::CMD_MIRROR: begin
        if (link.kind != mpc_pkg::KIND_BYTE) begin
          bad = 1'b1;
        end else if (link.wr) begin
          wr_mir = 1'b1;
        end else begin
          rd_d = 48'(cfg_q[1][mpc_pkg::TWO_PH_BIT]) << mpc_pkg::MIRROR_BIT;
        end
      end
      default: bad = 1'b1;
    endcase
  end

  // Shared image write; phase bits only change with page 0
  always_comb begin
    cfg_new = link.wdata;
    if (cfg_idx == 2'd1 && page_q) begin
      cfg_new[mpc_pkg::TWO_PH_BIT] = cfg_q[1][mpc_pkg::TWO_PH_BIT];
      cfg_new[mpc_pkg::THREE_PH_BIT] = cfg_q[1][mpc_pkg::THREE_PH_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Link answer
  // ---------------------------------------------------------------
  // One-cycle ack with registered data and error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= take;
      if (take) begin
        err_q <= bad;
        rdata_q <= (bad || link.wr) ? '0 : rd_d;
      end
    end
  end

  assign link.ack = ack_q;
  assign link.err = err_q;
  assign link.rdata = rdata_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Page select from latest accepted page write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_q <= 1'b0;
    end else if (take && wr_page) begin
      page_q <= link.wdata[0];
    end
  end

  // Shared configuration images
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 3; i++) begin
        cfg_q[i] <= '0;
      end
    end else if (nvm_load) begin
      cfg_q[0] <= nvm_cfg_ten;
      cfg_q[1] <= nvm_cfg_eleven;
      cfg_q[2] <= nvm_cfg_twelve;
    end else if (take && |wr_cfg) begin
      cfg_q[cfg_idx] <= cfg_new;
    end else if (take && wr_mir && !page_q) begin
      cfg_q[1][mpc_pkg::TWO_PH_BIT] <= link.wdata[mpc_pkg::MIRROR_BIT];
    end
  end

  // Paged limit and share words, one copy per page
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      limit_q[0] <= '0;
      limit_q[1] <= '0;
    end else if (nvm_load) begin
      limit_q[0] <= nvm_limit_p0;
      limit_q[1] <= nvm_limit_p1;
    end else if (take && wr_lim) begin
      limit_q[page_q] <= link.wdata[13:0];
    end
  end

  // Sticky imbalance flags; a new event beats the read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_a_q <= '0;
      flags_b_q <= '0;
    end else begin
      flags_a_q <= (flags_a_q & ~{6{take && rd_imb && !page_q}}) | imb_event_a;
      flags_b_q <= (flags_b_q & ~{3{take && rd_imb && page_q}}) | imb_event_b;
    end
  end

  // ---------------------------------------------------------------
  // Settings out
  // ---------------------------------------------------------------
  // Channel B phase count; both selects set reads as one phase
  always_comb begin
    unique case ({cfg_q[1][mpc_pkg::TWO_PH_BIT], cfg_q[1][mpc_pkg::THREE_PH_BIT]})
      2'b00: chan_b_phase_count = 2'd2;
      2'b01: chan_b_phase_count = 2'd3;
      2'b10: chan_b_phase_count = 2'd1;
      2'b11: chan_b_phase_count = 2'd1;
    endcase
  end

  // Per-page fields
  assign chan_b_temp_sense_disable = limit_q[0][mpc_pkg::TEMP_OFF_BIT];
  assign fault_isolation_sel = limit_q[1][mpc_pkg::ISOL_BIT];
  assign chan_b_fixed_overvoltage_off = limit_q[1][mpc_pkg::OV_OFF_BIT];
  assign dac_offset_falling_a = dac_ofs(limit_q[0][mpc_pkg::DOWN_LSB +: 2]);
  assign dac_offset_falling_b = dac_ofs(limit_q[1][mpc_pkg::DOWN_LSB +: 2]);
  assign dac_offset_rising_a = dac_ofs(limit_q[0][mpc_pkg::UP_LSB +: 2]);
  assign dac_offset_rising_b = dac_ofs(limit_q[1][mpc_pkg::UP_LSB +: 2]);
  assign imbalance_warn_threshold_a = limit_q[0][mpc_pkg::SHARE_LSB +: 2];
  assign imbalance_warn_threshold_b = limit_q[1][mpc_pkg::SHARE_LSB +: 2];
  assign per_phase_current_limit_a = ocl_amps(limit_q[0][mpc_pkg::OCL_LSB +: 4]);
  assign per_phase_current_limit_b = ocl_amps(limit_q[1][mpc_pkg::OCL_LSB +: 4]);
endmodule
`default_nettype wire

// file: verilog/mpc_host_end.sv
// Purpose: Host end issuing block, word and byte transactions to the register bank.
// Assumes: Software programs it over AHB-Lite, single word transfers.
// Notes:   Zero wait states; one transaction in flight at a time.
`timescale 1ns/100ps
`default_nettype none
module mpc_host_end (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link to bank
  mpc_link_if.host link
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [10:0] ctrl_q;
  logic [47:0] wdata_q;
  logic [47:0] rdata_q;
  logic busy_q;
  logic done_q;
  logic err_q;
  logic wpend_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic go;

  assign addr_ok = hsel && hready && htrans[1];
  assign go = wpend_q && waddr_q == mpc_pkg::H_CTRL && hwdata[mpc_pkg::CTRL_GO_BIT] && !busy_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // Capture write address phase, register read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_q <= 1'b0;
      waddr_q <= '0;
      hrdata_q <= '0;
    end else begin
      wpend_q <= addr_ok && hwrite;
      waddr_q <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          mpc_pkg::H_CTRL: hrdata_q <= {21'h0, ctrl_q};
          mpc_pkg::H_WLO: hrdata_q <= wdata_q[31:0];
          mpc_pkg::H_WHI: hrdata_q <= {16'h0, wdata_q[47:32]};
          mpc_pkg::H_RLO: hrdata_q <= rdata_q[31:0];
          mpc_pkg::H_RHI: hrdata_q <= {16'h0, rdata_q[47:32]};
          mpc_pkg::H_STAT: hrdata_q <= {29'h0, err_q, done_q, busy_q};
          default: hrdata_q <= '0;
        endcase
      end
    end
  end

  // Software registers; control frozen while busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= '0;
      wdata_q <= '0;
    end else if (wpend_q && !busy_q) begin
      if (waddr_q == mpc_pkg::H_CTRL) begin
        ctrl_q <= hwdata[10:0];
      end
      if (waddr_q == mpc_pkg::H_WLO) begin
        wdata_q[31:0] <= hwdata;
      end
      if (waddr_q == mpc_pkg::H_WHI) begin
        wdata_q[47:32] <= hwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Link sequencing
  // ---------------------------------------------------------------
  // Request stands until ack; done and error stick until next go
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= '0;
    end else if (go) begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else if (busy_q && link.ack) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
      err_q <= link.err;
      rdata_q <= link.rdata;
    end
  end

  // Request fields come straight from the frozen registers
  assign link.req = busy_q;
  assign link.cmd = ctrl_q[7:0];
  assign link.kind = ctrl_q[mpc_pkg::CTRL_KIND_LSB +: 2];
  assign link.wr = ctrl_q[mpc_pkg::CTRL_WR_BIT];
  assign link.wdata = wdata_q;
endmodule
`default_nettype wire

// file: testbench/mpc_link_chk.sv
// Purpose: Concurrent checks on the link between host end and register bank.
// Assumes: One clock, active-low asynchronous reset.
// Notes:   Page is followed from accepted page writes.
`timescale 1ns/100ps
`default_nettype none
module mpc_link_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request
  input wire logic req,
  input wire logic [1:0] kind,
  input wire logic wr,
  input wire logic [7:0] cmd,
  input wire logic [47:0] wdata,
  // Answer
  input wire logic ack,
  input wire logic err,
  input wire logic [47:0] rdata
);
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  logic page_q;
  logic is_img;
  logic rd_ok;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Decoded answer kinds
  assign is_img = cmd >= mpc_pkg::CMD_CFG_TEN && cmd <= mpc_pkg::CMD_CFG_TWELVE;
  assign rd_ok = ack && !err && !wr;
  // Page last accepted on the link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_q <= 1'b0;
    end else if (ack && !err && wr && cmd == mpc_pkg::CMD_PAGE) begin
      page_q <= wdata[0];
    end
  end
  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  a_take_answered: assert property ((req && !ack) |=> ack)
    else $error("no answer after take");
  a_ack_single: assert property (ack |=> !ack && !req)
    else $error("ack or req held too long");
  a_req_steady: assert property ((req && !ack) |=> $stable({cmd, kind, wr, wdata}))
    else $error("request moved before ack");
  a_img_block: assert property (ack && is_img && kind != mpc_pkg::KIND_BLOCK |-> err)
    else $error("image taken without block");
  a_limit_word: assert property (ack && cmd == mpc_pkg::CMD_LIMIT && kind != mpc_pkg::KIND_WORD |-> err)
    else $error("limit taken without word");
  a_status_ro: assert property (ack && cmd == mpc_pkg::CMD_IMB && wr |-> err && rdata == 48'h0)
    else $error("status write accepted");
  a_limit_top: assert property (rd_ok && cmd == mpc_pkg::CMD_LIMIT |-> rdata[47:14] == 34'h0)
    else $error("limit top bits set");
  a_status_top: assert property (rd_ok && cmd == mpc_pkg::CMD_IMB |-> rdata[47:9] == 39'h0)
    else $error("status top bits set");
  a_chb_flags: assert property (rd_ok && cmd == mpc_pkg::CMD_IMB && page_q |-> rdata[8:6] == 3'h0)
    else $error("channel B shows phases 4 to 6");
  a_answer_holds: assert property (ack |=> $stable(rdata) && $stable(err))
    else $error("answer dropped early");
endmodule
`default_nettype wire

// file: testbench/multiphase_config_regs_test.sv
// Purpose: Self-checking bench joining host end and register bank.
// Assumes: Zero-wait AHB-Lite slave; link kinds 0 byte, 1 word, 2 block.
// Notes:   A reference model predicts every link answer and setting.
`timescale 1ns/100ps
`default_nettype none
module multiphase_config_regs_test;
  // -------------------------------------------------------------
  // Signals and model state
  // -------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, nvm_load;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, chan_b_phase_count, imbalance_warn_threshold_a, imbalance_warn_threshold_b;
  logic [2:0] hsize, imb_event_b, active_phases_a, active_phases_b;
  logic [2:0] dac_offset_falling_a, dac_offset_falling_b, dac_offset_rising_a, dac_offset_rising_b;
  logic [5:0] imb_event_a, fla;
  logic [47:0] nvm_cfg_ten, nvm_cfg_eleven, nvm_cfg_twelve;
  logic [13:0] nvm_limit_p0, nvm_limit_p1;
  logic chan_b_temp_sense_disable, fault_isolation_sel, chan_b_fixed_overvoltage_off, pg;
  logic [6:0] per_phase_current_limit_a, per_phase_current_limit_b;
  logic [47:0] img [3];
  logic [13:0] lim [2];
  logic [2:0] flb;
  integer seed = 32'ha193cb84;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  assign hready = hreadyout;
  mpc_link_if mpc_link_if_inst ();
  mpc_host_end mpc_host_end_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .link(mpc_link_if_inst.host));
  mpc_dev_end mpc_dev_end_inst (.hclk, .hresetn, .link(mpc_link_if_inst.dev), .nvm_load, .nvm_cfg_ten,
    .nvm_cfg_eleven, .nvm_cfg_twelve, .nvm_limit_p0, .nvm_limit_p1, .imb_event_a, .imb_event_b,
    .active_phases_a, .active_phases_b, .chan_b_phase_count, .chan_b_temp_sense_disable, .fault_isolation_sel,
    .chan_b_fixed_overvoltage_off, .dac_offset_falling_a, .dac_offset_falling_b, .dac_offset_rising_a,
    .dac_offset_rising_b, .imbalance_warn_threshold_a, .imbalance_warn_threshold_b, .per_phase_current_limit_a,
    .per_phase_current_limit_b);
  mpc_link_chk mpc_link_chk_inst (.hclk, .hresetn, .req(mpc_link_if_inst.req), .kind(mpc_link_if_inst.kind),
    .wr(mpc_link_if_inst.wr), .cmd(mpc_link_if_inst.cmd), .wdata(mpc_link_if_inst.wdata),
    .ack(mpc_link_if_inst.ack), .err(mpc_link_if_inst.err), .rdata(mpc_link_if_inst.rdata));
  // Clock at 40 MHz
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("ERROR %0t timeout", $time);
      conclude();
    end
  end
  // -------------------------------------------------------------
  // Tasks and model
  // -------------------------------------------------------------
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [47:0] r48();
    logic [63:0] t;
    t = {$random(seed), $random(seed)};
    return t[47:0];
  endfunction
  // One AHB single transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // Expected answer, updating the model
  function automatic void model(input logic [1:0] k, input logic w, input logic [7:0] c, input logic [47:0] d,
    output logic e, output logic [47:0] r);
    e = 1'b0;
    r = 48'h0;
    if (c == mpc_pkg::CMD_PAGE && k == 2'd0) begin
      e = w && d[7:1] != 7'h0;
      if (w && !e) pg = d[0];
      if (!w) r = {47'h0, pg};
    end else if (c >= mpc_pkg::CMD_CFG_TEN && c <= mpc_pkg::CMD_CFG_TWELVE && k == 2'd2) begin
      if (c == mpc_pkg::CMD_CFG_ELEVEN && pg) d[9:8] = img[1][9:8];
      if (w) img[c - mpc_pkg::CMD_CFG_TEN] = d;
      else r = img[c - mpc_pkg::CMD_CFG_TEN];
    end else if (c == mpc_pkg::CMD_LIMIT && k == 2'd1) begin
      if (w) lim[pg] = d[13:0];
      else r = {34'h0, lim[pg]};
    end else if (c == mpc_pkg::CMD_IMB && k == 2'd1 && !w) begin
      r = pg ? {42'h0, flb, active_phases_b} : {39'h0, fla, active_phases_a};
      if (pg) flb = 3'h0;
      else fla = 6'h0;
    end else if (c == mpc_pkg::CMD_MIRROR && k == 2'd0) begin
      if (w && !pg) img[1][9] = d[0];
      if (!w) r = {47'h0, img[1][9]};
    end else begin
      e = 1'b1;
    end
  endfunction
  // Link transaction through the host registers, checked against the model
  task automatic op(input logic [1:0] k, input logic w, input logic [7:0] c, input logic [47:0] d);
    logic e;
    logic [47:0] r;
    logic [31:0] s, lo, hi;
    model(k, w, c, d, e, r);
    ahb(1'b1, mpc_pkg::H_WLO, d[31:0], s);
    ahb(1'b1, mpc_pkg::H_WHI, {16'h0, d[47:32]}, s);
    ahb(1'b1, mpc_pkg::H_CTRL, {1'b1, 20'h0, w, k, c}, s);
    s = 32'h1;
    while (s[0] !== 1'b0) ahb(1'b0, mpc_pkg::H_STAT, 32'h0, s);
    ahb(1'b0, mpc_pkg::H_RLO, 32'h0, lo);
    ahb(1'b0, mpc_pkg::H_RHI, 32'h0, hi);
    cmp({47'h0, s[2]}, {47'h0, e});
    cmp({47'h0, hresp}, 48'h0);
    if (!w) cmp({hi[15:0], lo}, r);
  endtask
  task automatic setp(input int p);
    op(2'd0, 1'b1, mpc_pkg::CMD_PAGE, 48'(p));
  endtask
  task automatic chk_outs();
    cmp(chan_b_phase_count, img[1][9] ? 48'd1 : img[1][8] ? 48'd3 : 48'd2);
    cmp(chan_b_temp_sense_disable, lim[0][13]);
    cmp(fault_isolation_sel, lim[1][12]);
    cmp(chan_b_fixed_overvoltage_off, lim[1][11]);
    cmp(dac_offset_falling_a, 48'(2 * lim[0][9:8]));
    cmp(dac_offset_falling_b, 48'(2 * lim[1][9:8]));
    cmp(dac_offset_rising_a, 48'(2 * lim[0][7:6]));
    cmp(dac_offset_rising_b, 48'(2 * lim[1][7:6]));
    cmp(imbalance_warn_threshold_a, lim[0][5:4]);
    cmp(imbalance_warn_threshold_b, lim[1][5:4]);
    cmp(per_phase_current_limit_a, 48'(14 + 4 * lim[0][3:0]));
    cmp(per_phase_current_limit_b, 48'(14 + 4 * lim[1][3:0]));
  endtask
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    int p;
    logic [47:0] v;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, nvm_load, imb_event_a, imb_event_b} = '0;
    hsize = 3'h2;
    {active_phases_a, active_phases_b} = 6'(r48());
    {nvm_cfg_ten, nvm_cfg_eleven, nvm_cfg_twelve} = {r48(), r48(), r48()};
    {nvm_limit_p0, nvm_limit_p1} = 28'(r48());
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    nvm_load <= 1'b1;
    @(posedge hclk);
    nvm_load <= 1'b0;
    img = '{nvm_cfg_ten, nvm_cfg_eleven, nvm_cfg_twelve};
    lim = '{nvm_limit_p0, nvm_limit_p1};
    {pg, fla, flb} = '0;
    // Loaded defaults and random settings, seen from both pages
    for (p = 0; p < 8; p++) begin
      setp(p & 1);
      op(2'd0, 1'b0, mpc_pkg::CMD_PAGE, 48'h0);
      if (p > 1) op(2'd1, 1'b1, mpc_pkg::CMD_LIMIT, r48() & 48'hffff);
      for (int i = 0; i < 3; i++) if (p > 1) op(2'd2, 1'b1, mpc_pkg::CMD_CFG_TEN + 8'(i), r48());
      setp(~p & 1);
      op(2'd1, 1'b0, mpc_pkg::CMD_LIMIT, 48'h0);
      for (int i = 0; i < 3; i++) op(2'd2, 1'b0, mpc_pkg::CMD_CFG_TEN + 8'(i), 48'h0);
      chk_outs();
    end
    // Phase selection by read-modify-write, mirror both ways
    setp(0);
    for (int i = 0; i < 4; i++) begin
      op(2'd2, 1'b0, mpc_pkg::CMD_CFG_ELEVEN, 48'h0);
      v = img[1];
      v[9:8] = 2'(i + 2);
      op(2'd2, 1'b1, mpc_pkg::CMD_CFG_ELEVEN, v);
      op(2'd0, 1'b0, mpc_pkg::CMD_MIRROR, 48'h0);
      chk_outs();
      op(2'd0, 1'b1, mpc_pkg::CMD_MIRROR, {47'h0, ~v[9]});
      op(2'd2, 1'b0, mpc_pkg::CMD_CFG_ELEVEN, 48'h0);
    end
    // Refused kinds leave state alone
    op(2'd1, 1'b0, mpc_pkg::CMD_CFG_TEN, 48'h0);
    op(2'd0, 1'b1, mpc_pkg::CMD_CFG_TWELVE, r48());
    op(2'd2, 1'b1, mpc_pkg::CMD_LIMIT, r48());
    op(2'd0, 1'b0, mpc_pkg::CMD_IMB, 48'h0);
    // Mirror write with page 1 leaves the two-phase select alone; page value 2 and code 8'h55 refused
    setp(1);
    op(2'd0, 1'b1, mpc_pkg::CMD_MIRROR, {47'h0, ~img[1][9]});
    op(2'd2, 1'b0, mpc_pkg::CMD_CFG_ELEVEN, 48'h0);
    setp(2);
    op(2'd1, 1'b0, 8'h55, 48'h0);
    // Imbalance flags, live phase counts, clear on read
    imb_event_a <= 6'(r48());
    imb_event_b <= 3'(r48());
    @(posedge hclk);
    fla = imb_event_a;
    flb = imb_event_b;
    imb_event_a <= 6'h0;
    imb_event_b <= 3'h0;
    op(2'd1, 1'b1, mpc_pkg::CMD_IMB, 48'h1f8);
    for (p = 0; p < 2; p++) begin
      setp(p);
      op(2'd1, 1'b0, mpc_pkg::CMD_IMB, 48'h0);
      op(2'd1, 1'b0, mpc_pkg::CMD_IMB, 48'h0);
    end
    op(2'd1, 1'b0, mpc_pkg::CMD_LIMIT, 48'h0);
    conclude();
  end
endmodule
`default_nettype wire
